// file: bench/asi_codec_model.sv
// behavioural codec: bit clocks, frame syncs, receive data and capture of transmit data
`timescale 1ns/1ps
module asi_codec_model (
   // frame commands
   input wire logic go,
   input wire logic [5:0] len,
   input wire logic [31:0] word,
   input wire logic inv,
   input wire logic fsr_on,
   input wire logic clkr_on,
   input wire logic xfall,
   // link
   input wire logic dx,
   output asi_pkg::asi_link_in_s link,
   output logic [31:0] got,
   output logic done
);
   // one frame per rising go; clocks stand still between frames
   initial begin
      link = 5'h00;
      got = 32'h0000_0000;
      done = 1'b0;
      forever begin
         @(posedge go);
         #7;
         done = 1'b0;
         got = 32'h0000_0000;
         link.fsx = inv;
         link.fsr = inv;
         #160;
         link.fsx = ~inv;
         link.fsr = fsr_on ? ~inv : inv;
         link.dr = word[len - 1];
         for (int i = 0; i <= len; i++) begin
            #160;
            link.clkx = 1'b1;
            link.clkr = clkr_on;
            got = (i > 0 && !xfall) ? {got[30:0], dx} : got;
            #80;
            link.fsx = (i == 1) ? inv : link.fsx;
            link.fsr = (i == 1) ? inv : link.fsr;
            #80;
            link.clkx = 1'b0;
            link.clkr = 1'b0;
            got = (i > 0 && xfall) ? {got[30:0], dx} : got;
            // past the last bit the line is released: show a changing level
            link.dr = (i + 2 <= len) ? word[len - 2 - i] : ~link.dr;
         end
         done = 1'b1;
      end
   end
endmodule : asi_codec_model

// file: bench/asi_config_props.sv
// concurrent checks on the ports of the audio serial config block
`timescale 1ns/1ps
module asi_config_props (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // bus side
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // serial side
   input wire asi_pkg::asi_link_in_s link_i,
   input wire logic dx_o,
   input wire logic dx_oe
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic [31:0] cfg_q;
   logic wcfg_q;
   logic x1_q;
   logic x2_q;
   logic [3:0] since_q;
   // decoded requests; edge seen one flop late, so the window below is generous
   wire take = hsel && htrans[1] && hready;
   wire rd_take = take && !hwrite;
   wire cfg_hit = haddr[7:0] == asi_pkg::ASI_CFG_OFS;
   wire known = cfg_hit || haddr[7:0] == asi_pkg::ASI_STAT_OFS
      || haddr[7:0] == asi_pkg::ASI_TXD_OFS || haddr[7:0] == asi_pkg::ASI_RXD_OFS;
   wire sel_edge = (x1_q != x2_q) && (x1_q != cfg_q[9]);
   // shadow config and age of the last selected transmit clock edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_q <= asi_pkg::ASI_CFG_RST;
         wcfg_q <= 1'b0;
         x1_q <= 1'b0;
         x2_q <= 1'b0;
         since_q <= 4'hF;
      end else begin
         wcfg_q <= take && hwrite && cfg_hit;
         cfg_q <= wcfg_q ? hwdata : cfg_q;
         x1_q <= link_i.clkx;
         x2_q <= x1_q;
         since_q <= sel_edge ? 4'h0 : (since_q == 4'hF ? since_q : since_q + 4'h1);
      end
   end
   chk_ready_high: assert property (hreadyout == 1'b1) else $error("wait state seen");
   chk_resp_okay: assert property (hresp == 1'b0) else $error("error response seen");
   chk_cfg_readback:
   assert property (rd_take && cfg_hit && !wcfg_q |=> hrdata == cfg_q)
      else $error("config readback differs");
   chk_unmapped_zero: assert property (rd_take && !known |=> hrdata == asi_pkg::ASI_ZERO32)
      else $error("unmapped read not zero");
   chk_rdata_holds: assert property (!$past(rd_take) |-> $stable(hrdata))
      else $error("read data moved");
   chk_oe_tracks_cfg:
   assert property (dx_oe == cfg_q[3]) else $error("output enable differs from config");
   chk_dx_after_edge:
   assert property ($changed(dx_o) |-> since_q <= 4'h5) else $error("data moved off edge");
   chk_idle_from_reset:
   assert property ($rose(hresetn) |-> !dx_oe && !dx_o) else $error("data pin active");
endmodule : asi_config_props

// file: bench/asi_config_top_test.sv
// self-checking bench for the audio serial config block
`timescale 1ns/1ps
module asi_config_top_test;
   localparam logic [7:0] CFG = asi_pkg::ASI_CFG_OFS;
   localparam logic [31:0] Z = asi_pkg::ASI_ZERO32;
   localparam logic [31:0] W = 32'hC3A5_96E1;
   localparam logic [31:0] L = 32'h5E0F_A3B6;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, dx_o, dx_oe;
   logic [31:0] haddr, hwdata, hrdata, word, got;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [5:0] len;
   logic go, inv, fsr_on, clkr_on, xfall, done;
   asi_pkg::asi_link_in_s link;
   int miscompares, tests_run;
   // single slave: its ready is the bus ready
   assign hready = hreadyout;
   always #20 hclk = ~hclk;
   asi_config_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link_i(link), .dx_o(dx_o),
      .dx_oe(dx_oe));
   asi_codec_model u_codec (.go(go), .len(len), .word(word), .inv(inv), .fsr_on(fsr_on),
      .clkr_on(clkr_on), .xfall(xfall), .dx(dx_o), .link(link), .got(got), .done(done));
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   // no wait is trusted to end: a spent bound closes the run
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (n >= 20) begin
         miscompares++;
         end_sim();
      end
   endtask : wait_rdy
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= 2'h2;
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      r = hrdata;
   endtask : bus
   task automatic frame;
      int n;
      go <= 1'b1;
      @(posedge hclk);
      go <= 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 1000) begin
         @(posedge hclk);
         n++;
      end
      if (n >= 1000) begin
         miscompares++;
         end_sim();
      end
   endtask : frame
   task automatic t_reset;
      logic [31:0] r;
      bus(CFG, 1'b0, Z, r);
      chk(r, asi_pkg::ASI_CFG_RST);
      chk({31'h0, dx_oe}, Z);
      bus(8'h40, 1'b1, 32'hFFFF_FFFF, r);
      bus(8'h40, 1'b0, Z, r);
      chk(r, Z);
      $display("reset and unmapped test done");
   endtask : t_reset
   task automatic t_cfg;
      logic [31:0] r;
      logic [31:0] v[3] = '{32'hD5A5_E700, 32'h2A5A_1800, asi_pkg::ASI_CFG_RST};
      for (int k = 0; k < 3; k++) begin
         bus(CFG, 1'b1, v[k], r);
         bus(CFG, 1'b0, Z, r);
         chk(r, v[k]);
      end
      $display("config readback test done");
   endtask : t_cfg
   // width rows: 32, 8, 16 (with ac97 clamp to 20 bits), 64; row 1 on falling edge
   task automatic t_tx;
      logic [31:0] r;
      logic [63:0] e;
      int n, b;
      logic [1:0] sz[4] = '{2'h2, 2'h0, 2'h1, 2'h3};
      logic [5:0] ln[4] = '{6'h18, 6'h20, 6'h20, 6'h08};
      for (int k = 0; k < 4; k++) begin
         b = (sz[k] == 2'h0) ? 1 : (sz[k] == 2'h1) ? 2 : 4;
         bus(CFG, 1'b1, {sz[k], 6'h00, 2'h2, ln[k], 6'h00, k == 1, 5'h00, 1'b1, 2'h0, k == 2},
            r);
         for (int j = 0; j < 4; j += b) bus(asi_pkg::ASI_TXD_OFS, 1'b1, W >> (8 * j), r);
         {fsr_on, clkr_on, inv} <= 3'h4;
         len <= ln[k];
         word <= Z;
         xfall <= (k == 1);
         frame();
         n = (k == 2) ? 20 : ln[k];
         e = (64'(W) & ((64'h1 << n) - 64'h1)) << (ln[k] - n);
         chk(got, e[31:0]);
         chk({31'h0, dx_oe}, 32'h0000_0001);
      end
      $display("transmit test done");
   endtask : t_tx
   // sync, clock and polarity choices; last row loops transmit back on the falling edge
   task automatic t_rx;
      logic [31:0] r;
      logic [7:0] mid[6] = '{8'h0C, 8'h2C, 8'h00, 8'h10, 8'h10, 8'h41};
      logic [3:0] fl[6] = '{4'hB, 4'h3, 4'h0, 4'h8, 4'hD, 4'h9};
      for (int k = 0; k < 6; k++) begin
         bus(CFG, 1'b1, {16'h9090, mid[k], (k == 5) ? 8'h0C : 8'h04}, r);
         bus(asi_pkg::ASI_TXD_OFS, 1'b1, L, r);
         {fsr_on, clkr_on, inv} <= fl[k][3:1];
         len <= 6'h10;
         word <= W;
         xfall <= 1'b0;
         frame();
         bus(asi_pkg::ASI_RXD_OFS, 1'b0, Z, r);
         chk(r, !fl[k][0] ? Z : {16'h0000, (k == 5) ? L[15:0] : W[15:0]});
      end
      $display("receive test done");
   endtask : t_rx
   // reset, then the scenarios in turn
   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      {hsel, hwrite, go, inv, fsr_on, clkr_on, xfall} = 7'h00;
      {haddr, hwdata, word} = {3{Z}};
      {htrans, hsize, len} = {2'h0, 3'h2, 6'h00};
      miscompares = 0;
      tests_run = 0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_cfg();
      t_tx();
      t_rx();
      end_sim();
   end
endmodule : asi_config_top_test
bind asi_config_top asi_config_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link_i(link_i), .dx_o(dx_o),
   .dx_oe(dx_oe));

// file: hdl/asi_config_top.sv
// audio serial interface: config register, word holding, serializer and deserializer
`timescale 1ns/1ps

// Operation
// - transmit bus write width from bits 31-30: 8, 16, 32 or 64 bits.
// - receive bus read width from bits 23-22, same encoding, resets to 32-bit.
// - receiver deserializes bits 29-24 bits per channel, max 32 I2S, 20 AC97.
// - transmitter serializes bits 21-16 bits per channel, max 32 I2S, 20 AC97.
// - bit 15 set in I2S mode receives two channels per frame, else one.
// - bit 14 set loops transmit data back into the receive path.
// - bit 13 set makes receive use the transmit frame sync.
// - bit 12 clear shares transmit bit clock; set uses separate receive clock.
// - bit 11 inverts the transmit frame sync when set.
// - bit 10 inverts the receive frame sync when set.
// - transmit data changes on rising bit clock edge, falling if bit 9 set.
// - receive frame and data sampled on rising edge, falling if bit 8 set.
// - bit 0 clear selects I2S mode, set selects AC97 mode.
// - transmit data tri-stated until transmit enable; then words popped and serialized.
module asi_config_top (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // serial link
   input wire asi_pkg::asi_link_in_s link_i,
   output logic dx_o,
   output logic dx_oe
);

   // clamp a per-channel bit count to the limit of the active mode
   function automatic logic [5:0] clamp_len(input logic [5:0] f, input logic ac97);
      logic [5:0] lim;
      lim = ac97 ? asi_pkg::ASI_AC97_MAX_LEN : asi_pkg::ASI_I2S_MAX_LEN;
      return (f > lim) ? lim : f;
   endfunction : clamp_len

   // bytes moved per bus access for a size field; 64-bit is two word accesses
   function automatic logic [2:0] acc_bytes(input logic [1:0] sz);
      return (sz == asi_pkg::ASI_ACC_8) ? asi_pkg::ASI_BYTES_1 :
             (sz == asi_pkg::ASI_ACC_16) ? asi_pkg::ASI_BYTES_2 : asi_pkg::ASI_BYTES_4;
   endfunction : acc_bytes

   asi_pkg::asi_cfg_s cfg_q;
   logic wr_q;
   logic [7:0] addr_q;
   logic [31:0] hrdata_q;
   logic [4:0] sy1_q, sy2_q, prv_q;
   logic [31:0] tx_buf_q, tx_sh_q, rx_buf_q, rx_sh_q;
   logic [2:0] tx_cnt_q, rx_cnt_q;
   logic [5:0] tx_left_q, rx_cnt_bits_q;
   logic dx_q, txfs_q, rxfs_q;
   logic tx_under_q, rx_over_q;

   // ---------------- bus decode ----------------
   wire addr_ph = hsel & htrans[1] & hready;
   wire [7:0] a_now = haddr[7:0];
   wire rd_ph = addr_ph & ~hwrite;
   wire cfg_wr = wr_q & (addr_q == asi_pkg::ASI_CFG_OFS);
   wire stat_wr = wr_q & (addr_q == asi_pkg::ASI_STAT_OFS);
   wire tx_full = (tx_cnt_q == asi_pkg::ASI_BYTES_4);
   wire rx_avail = (rx_cnt_q != 3'h0);
   wire tx_wr = wr_q & (addr_q == asi_pkg::ASI_TXD_OFS) & ~tx_full;
   wire rx_pop = rd_ph & (a_now == asi_pkg::ASI_RXD_OFS) & rx_avail;
   wire [2:0] tx_bytes = acc_bytes(cfg_q.tx_fifo_size);
   wire [2:0] rx_bytes = acc_bytes(cfg_q.rx_fifo_size);

   // ---------------- link edges ----------------
   // sy1 feeds sy2 only; every edge detector looks at sy2 and its delayed copy
   wire clkx_rise = sy2_q[4] & ~prv_q[4];
   wire clkx_fall = ~sy2_q[4] & prv_q[4];
   wire rclk_now = cfg_q.rx_bitclk_sep ? sy2_q[3] : sy2_q[4];
   wire rclk_prv = cfg_q.rx_bitclk_sep ? prv_q[3] : prv_q[4];
   wire tx_edge = cfg_q.clkx_pol ? clkx_fall : clkx_rise;
   wire rx_edge = cfg_q.clkr_pol ? (~rclk_now & rclk_prv) : (rclk_now & ~rclk_prv);
   wire fsx_lvl = sy2_q[2] ^ cfg_q.fsx_pol;
   wire fsr_own = sy2_q[1] ^ cfg_q.fsr_pol;
   wire fsr_lvl = cfg_q.common_sync ? fsx_lvl : fsr_own;
   wire rx_bit = cfg_q.loop_back ? dx_q : sy2_q[0];

   // ---------------- mode dependent settings ----------------
   // stereo only means something in I2S; AC97 takes one slot per sync
   wire tx_two = cfg_q.tx_stereo & ~cfg_q.mode;
   wire rx_two = cfg_q.rx_stereo & ~cfg_q.mode;
   wire [5:0] tx_len = clamp_len(cfg_q.tx_len, cfg_q.mode);
   wire [5:0] rx_len = clamp_len(cfg_q.rx_len, cfg_q.mode);

   // ---------------- transmit sequencing ----------------
   // a channel opens on the sync's leading edge, and on its trailing edge in stereo
   wire tx_start = tx_edge & ((fsx_lvl & ~txfs_q) | (tx_two & ~fsx_lvl & txfs_q));
   wire tx_take = tx_start & cfg_q.ena_tx & tx_full;
   wire tx_miss = tx_start & cfg_q.ena_tx & ~tx_full;
   wire [31:0] tx_word = tx_take ? tx_buf_q : asi_pkg::ASI_ZERO32;
   wire [5:0] tx_len_m1 = tx_len - asi_pkg::ASI_ONE_BIT;
   wire [5:0] tx_left_m1 = tx_left_q - asi_pkg::ASI_ONE_BIT;
   wire tx_first = tx_word[tx_len_m1[4:0]];
   wire tx_next = tx_sh_q[tx_left_m1[4:0]];

   // ---------------- receive sequencing ----------------
   wire rx_start = rx_edge & ((fsr_lvl & ~rxfs_q) | (rx_two & ~fsr_lvl & rxfs_q));
   wire rx_going = (rx_cnt_bits_q != 6'h00) & (rx_cnt_bits_q < rx_len);
   wire rx_active = rx_start | (rx_edge & rx_going);
   wire [5:0] rx_cnt_next = rx_start ? asi_pkg::ASI_ONE_BIT
                                     : rx_cnt_bits_q + asi_pkg::ASI_ONE_BIT;
   wire [31:0] rx_sh_next = rx_start ? {31'h0000_0000, rx_bit} : {rx_sh_q[30:0], rx_bit};
   wire rx_push = rx_active & (rx_cnt_next == rx_len) & cfg_q.ena_rx;
   wire rx_accept = rx_push & ~rx_avail;
   wire rx_drop = rx_push & rx_avail;

   // ---------------- holding word updates ----------------
   // writes enter at the high end and shift down so the first byte written ends in bits 7:0
   wire [31:0] tx_buf_d = (tx_bytes == asi_pkg::ASI_BYTES_1) ? {hwdata[7:0], tx_buf_q[31:8]} :
                          (tx_bytes == asi_pkg::ASI_BYTES_2) ? {hwdata[15:0], tx_buf_q[31:16]} :
                          hwdata;
   wire [3:0] tx_sum = {1'b0, tx_cnt_q} + {1'b0, tx_bytes};
   // mixed widths without a flush would overflow; the count saturates at a full word
   wire [2:0] tx_cnt_d = (tx_sum > {1'b0, asi_pkg::ASI_BYTES_4}) ? asi_pkg::ASI_BYTES_4
                                                                 : tx_sum[2:0];
   wire [31:0] rx_rd_val = (rx_bytes == asi_pkg::ASI_BYTES_1) ? {24'h00_0000, rx_buf_q[7:0]} :
                           (rx_bytes == asi_pkg::ASI_BYTES_2) ? {16'h0000, rx_buf_q[15:0]} :
                           rx_buf_q;
   wire [31:0] rx_buf_pop = (rx_bytes == asi_pkg::ASI_BYTES_1) ? {8'h00, rx_buf_q[31:8]} :
                            (rx_bytes == asi_pkg::ASI_BYTES_2) ? {16'h0000, rx_buf_q[31:16]} :
                            asi_pkg::ASI_ZERO32;
   wire [2:0] rx_cnt_pop = (rx_cnt_q > rx_bytes) ? (rx_cnt_q - rx_bytes) : 3'h0;

   // ---------------- read data ----------------
   wire [31:0] stat_val = {28'h000_0000, rx_over_q, tx_under_q, rx_avail, ~tx_full};
   wire [31:0] rd_val = (a_now == asi_pkg::ASI_CFG_OFS) ? cfg_q :
                        (a_now == asi_pkg::ASI_STAT_OFS) ? stat_val :
                        (a_now == asi_pkg::ASI_RXD_OFS && rx_avail) ? rx_rd_val :
                        asi_pkg::ASI_ZERO32;

   // zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;
   assign dx_o = dx_q;
   assign dx_oe = cfg_q.ena_tx;

   // bus address phase capture and registered read data
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         addr_q <= 8'h00;
         hrdata_q <= asi_pkg::ASI_ZERO32;
      end else begin
         wr_q <= addr_ph & hwrite;
         addr_q <= a_now;
         if (rd_ph) begin
            hrdata_q <= rd_val;
         end
      end
   end

   // configuration register; hsize is ignored since only word accesses arrive
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_q <= asi_pkg::ASI_CFG_RST;
      end else if (cfg_wr) begin
         cfg_q <= hwdata;
      end
   end

   // sticky error flags: a new event wins over a clear in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_under_q <= 1'b0;
         rx_over_q <= 1'b0;
      end else begin
         tx_under_q <= tx_miss | (tx_under_q & ~(stat_wr & hwdata[asi_pkg::ASI_ST_TX_UNDER]));
         rx_over_q <= rx_drop | (rx_over_q & ~(stat_wr & hwdata[asi_pkg::ASI_ST_RX_OVER]));
      end
   end

   // link pin synchronisers plus one delayed copy for edge finding
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sy1_q <= 5'h00;
         sy2_q <= 5'h00;
         prv_q <= 5'h00;
      end else begin
         sy1_q <= link_i;
         sy2_q <= sy1_q;
         prv_q <= sy2_q;
      end
   end

   // transmit holding word: filled by the bus, emptied at a channel start
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_buf_q <= asi_pkg::ASI_ZERO32;
         tx_cnt_q <= 3'h0;
      end else if (tx_wr) begin
         tx_buf_q <= tx_buf_d;
         tx_cnt_q <= tx_cnt_d;
      end else if (tx_take) begin
         tx_cnt_q <= 3'h0;
      end
   end

   // serializer: msb of the channel first, one bit per selected edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         txfs_q <= 1'b0;
         tx_sh_q <= asi_pkg::ASI_ZERO32;
         tx_left_q <= 6'h00;
         dx_q <= 1'b0;
      end else if (tx_edge) begin
         txfs_q <= fsx_lvl;
         if (tx_start && tx_len != 6'h00) begin
            tx_sh_q <= tx_word;
            tx_left_q <= tx_len_m1;
            dx_q <= tx_first & cfg_q.ena_tx;
         end else if (tx_left_q != 6'h00) begin
            tx_left_q <= tx_left_m1;
            dx_q <= tx_next & cfg_q.ena_tx;
         end else begin
            dx_q <= 1'b0;
         end
      end
   end

   // deserializer: shifts in at the selected edge until the channel length is met
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rxfs_q <= 1'b0;
         rx_sh_q <= asi_pkg::ASI_ZERO32;
         rx_cnt_bits_q <= 6'h00;
      end else if (rx_edge) begin
         rxfs_q <= fsr_lvl;
         if (rx_active) begin
            rx_sh_q <= rx_sh_next;
            rx_cnt_bits_q <= rx_cnt_next;
         end
      end
   end

   // receive holding word: a finished channel loads it, bus reads drain it
   // a push is refused while bytes remain, so no same-cycle push and pop
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_buf_q <= asi_pkg::ASI_ZERO32;
         rx_cnt_q <= 3'h0;
      end else if (rx_accept) begin
         rx_buf_q <= rx_sh_next;
         rx_cnt_q <= asi_pkg::ASI_BYTES_4;
      end else if (rx_pop) begin
         rx_buf_q <= rx_buf_pop;
         rx_cnt_q <= rx_cnt_pop;
      end
   end

   // hsize carries no information here
   wire unused_ok = &{1'b0, hsize};

endmodule : asi_config_top

// file: hdl/asi_pkg.sv
// constants, register map and carrier types for the audio serial interface config block
package asi_pkg;

   // register byte offsets on the bus
   localparam logic [7:0] ASI_CFG_OFS = 8'h0C;
   localparam logic [7:0] ASI_STAT_OFS = 8'h14;
   localparam logic [7:0] ASI_TXD_OFS = 8'h18;
   localparam logic [7:0] ASI_RXD_OFS = 8'h1C;

   // values after reset
   localparam logic [31:0] ASI_CFG_RST = 32'h8080_0000;
   localparam logic [31:0] ASI_ZERO32 = 32'h0000_0000;

   // access size encodings of the two fifo size fields
   localparam logic [1:0] ASI_ACC_8 = 2'h0;
   localparam logic [1:0] ASI_ACC_16 = 2'h1;

   // byte counts of the holding words
   localparam logic [2:0] ASI_BYTES_1 = 3'h1;
   localparam logic [2:0] ASI_BYTES_2 = 3'h2;
   localparam logic [2:0] ASI_BYTES_4 = 3'h4;

   // per-channel bit count limits
   localparam logic [5:0] ASI_I2S_MAX_LEN = 6'h20;
   localparam logic [5:0] ASI_AC97_MAX_LEN = 6'h14;
   localparam logic [5:0] ASI_ONE_BIT = 6'h01;

   // status register bit positions
   localparam int ASI_ST_TX_READY = 0;
   localparam int ASI_ST_RX_AVAIL = 1;
   localparam int ASI_ST_TX_UNDER = 2;
   localparam int ASI_ST_RX_OVER = 3;

   // configuration register layout, msb first
   typedef struct packed {
      logic [1:0] tx_fifo_size;
      logic [5:0] rx_len;
      logic [1:0] rx_fifo_size;
      logic [5:0] tx_len;
      logic rx_stereo;
      logic loop_back;
      logic common_sync;
      logic rx_bitclk_sep;
      logic fsx_pol;
      logic fsr_pol;
      logic clkx_pol;
      logic clkr_pol;
      logic fsx_src;
      logic fsr_src;
      logic clkx_src;
      logic clkr_src;
      logic ena_tx;
      logic ena_rx;
      logic tx_stereo;
      logic mode;
   } asi_cfg_s;

   // serial link pins coming in from the codec
   typedef struct packed {
      logic clkx;
      logic clkr;
      logic fsx;
      logic fsr;
      logic dr;
   } asi_link_in_s;

endpackage : asi_pkg
